// ===== design/cbr_consts.svh
// Register offsets, field positions and reset values of the channel register bank.
`ifndef CBR_CONSTS_SVH
`define CBR_CONSTS_SVH

// Little-endian map offsets, used while the byte-order pin is high.
`define CBR_L_REV 8'h82
`define CBR_L_SEL 8'hEC
`define CBR_L_CMR 8'h18
`define CBR_L_OPT1 8'h13
`define CBR_L_OPT2 8'h14
`define CBR_L_OPT3 8'h15
`define CBR_L_OPT4 8'h16
`define CBR_L_OPT5 8'h17
`define CBR_L_OPT6 8'h1B
`define CBR_L_OPT7 8'h04
`define CBR_L_SPC1 8'h1C
`define CBR_L_SPC2 8'h1D
`define CBR_L_SPC3 8'h1E
`define CBR_L_SPC4 8'h1F
`define CBR_L_RNGL 8'h20
`define CBR_L_RNGH 8'h21
`define CBR_L_RXM2 8'h22
`define CBR_L_RXM3 8'h23
`define CBR_L_LNX 8'h2D
`define CBR_L_CRC 8'hD4
`define CBR_L_RBP 8'hC9
`define CBR_L_RCO 8'hCA
`define CBR_L_TBP 8'hC1
`define CBR_L_TCO 8'hC2
`define CBR_L_CMD 8'h10
`define CBR_L_STC 8'h11
`define CBR_L_STAT 8'h19
`define CBR_L_MRTS 8'hDC
`define CBR_L_MDTR 8'hDD

// Big-endian map offsets, used while the byte-order pin is low.
`define CBR_B_REV 8'h81
`define CBR_B_SEL 8'hEE
`define CBR_B_CMR 8'h1B
`define CBR_B_OPT1 8'h10
`define CBR_B_OPT2 8'h17
`define CBR_B_OPT3 8'h16
`define CBR_B_OPT4 8'h15
`define CBR_B_OPT5 8'h14
`define CBR_B_OPT6 8'h18
`define CBR_B_OPT7 8'h07
`define CBR_B_SPC1 8'h1F
`define CBR_B_SPC2 8'h1E
`define CBR_B_SPC3 8'h1D
`define CBR_B_SPC4 8'h1C
`define CBR_B_RNGL 8'h23
`define CBR_B_RNGH 8'h22
`define CBR_B_RXM2 8'h21
`define CBR_B_RXM3 8'h20
`define CBR_B_LNX 8'h2E
`define CBR_B_CRC 8'hD6
`define CBR_B_RBP 8'hCB
`define CBR_B_RCO 8'hC8
`define CBR_B_TBP 8'hC3
`define CBR_B_TCO 8'hC0
`define CBR_B_CMD 8'h13
`define CBR_B_STC 8'h12
`define CBR_B_STAT 8'h1A
`define CBR_B_MRTS 8'hDE
`define CBR_B_MDTR 8'hDF

// Reset values and field positions.
`define CBR_RST_SEL 8'h00
`define CBR_RST_REV 8'h00
`define CBR_SEL_CHAN_MSB 1
`define CBR_CAP_ASYNC 0
`define CBR_CAP_SYNC 1
`define CBR_CAP_PPP 2

`endif

// ===== design/cbr_pkg.sv
// Types shared by the channel register bank modules.
package cbr_pkg;

	// Bus access sequencer states, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_CAP = 4'h4,
		ST_RESP = 4'h8
	} cbr_state_t;

	// Protocol of a channel as held in the low bits of its mode register.
	typedef enum logic [1:0] {
		PR_ASYNC = 2'h0,
		PR_SYNC = 2'h1,
		PR_PPP = 2'h2,
		PR_NONE = 2'h3
	} cbr_proto_t;

	// Class of register that an access hits.
	typedef enum logic [2:0] {
		K_NONE = 3'h0,
		K_REV = 3'h1,
		K_SEL = 3'h2,
		K_CHAN = 3'h3,
		K_STAT = 3'h4
	} cbr_kind_t;

endpackage : cbr_pkg

// ===== design/cbr_sync2.sv
// Two-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
module cbr_sync2 (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic ff1;
		logic ff2;
	} cbr_sync_st_t;

	cbr_sync_st_t s_q;
	cbr_sync_st_t s_d;

	// The first flop feeds only the second one.
	always_comb begin
		s_d.ff1 = d;
		s_d.ff2 = s_q.ff1;
	end

	// Resets to the little-endian map so a floating pin has a known meaning.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.ff2;
endmodule : cbr_sync2

// ===== design/cbr_regmem.sv
// Byte memory that holds every per-channel register copy, with registered read data.
`timescale 1ns/1ps
module cbr_regmem #(
	parameter int AW = 11,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	localparam int DEPTH = 1 << AW;

	initial begin
		if (AW < 1 || AW > 12 || DW < 1) begin
			$error("cbr_regmem: unsupported geometry");
		end
	end

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
		logic [DW-1:0] rd;
	} cbr_mem_st_t;

	cbr_mem_st_t s_q;
	cbr_mem_st_t s_d;

	// Read returns the old byte when read and write hit the same word together.
	always_comb begin
		s_d = s_q;
		s_d.rd = s_q.mem[raddr];
		if (we) begin
			s_d.mem[waddr] = wdata;
		end
	end

	// Clearing the whole array on reset gives every copy a defined value.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rd;
endmodule : cbr_regmem

// ===== design/cbr_bank.sv
// APB register bank with one global set and four banked per-channel sets.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_bank #(
	parameter int NCHAN = 4,
	parameter logic [7:0] REV_INIT = `CBR_RST_REV
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic byte_order_pin,
	input wire logic ctx_active,
	input wire logic [1:0] ctx_channel,
	input wire logic [2:0] image_caps,
	output logic [1:0] active_chan,
	output cbr_pkg::cbr_proto_t active_proto,
	output logic [1:0] sel_channel,
	output logic map_little
);
	import cbr_pkg::*;

	localparam int SLOT_W = 9;
	localparam int MEM_AW = SLOT_W + 2;

	initial begin
		if (NCHAN != 4) begin
			$error("cbr_bank: channel select decodes exactly four channels");
		end
	end

	typedef struct packed {
		cbr_state_t st;
		logic [7:0] channel_select;
		logic [7:0] rev;
		logic [7:0] proto;
		logic [SLOT_W-1:0] slot;
		logic [1:0] chan;
		cbr_kind_t kind;
		logic err;
		logic wr;
		logic [7:0] wdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] act_chan;
		logic [1:0] act_proto;
		logic little;
	} cbr_bank_st_t;

	cbr_bank_st_t s_q;
	cbr_bank_st_t s_d;
	logic pin_sync;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic [1:0] eff_chan;
	logic [7:0] norm_ofs;
	cbr_kind_t dec_kind;
	logic [1:0] dec_var;
	logic dec_ok;
	logic [1:0] eff_proto;

	// Byte-order pin comes from outside the clock domain.
	cbr_sync2 u_sync (
		.clk(clk),
		.rst(rst),
		.d(byte_order_pin),
		.q(pin_sync)
	);

	// Every per-channel copy lives here, addressed by channel and slot.
	cbr_regmem #(
		.AW(MEM_AW),
		.DW(8)
	) u_mem (
		.clk(clk),
		.rst(rst),
		.we(mem_we),
		.waddr({s_q.chan, s_q.slot}),
		.wdata(s_q.wdata),
		.raddr({s_q.chan, s_q.slot}),
		.rdata(mem_rdata)
	);

	// Translate a big-endian map offset into the matching little-endian offset.
	function automatic logic [7:0] to_little(input logic [7:0] o);
		logic [7:0] r;
		r = 8'hFF;
		unique case (o)
			`CBR_B_REV: r = `CBR_L_REV;
			`CBR_B_SEL: r = `CBR_L_SEL;
			`CBR_B_CMR: r = `CBR_L_CMR;
			`CBR_B_OPT1: r = `CBR_L_OPT1;
			`CBR_B_OPT2: r = `CBR_L_OPT2;
			`CBR_B_OPT3: r = `CBR_L_OPT3;
			`CBR_B_OPT4: r = `CBR_L_OPT4;
			`CBR_B_OPT5: r = `CBR_L_OPT5;
			`CBR_B_OPT6: r = `CBR_L_OPT6;
			`CBR_B_OPT7: r = `CBR_L_OPT7;
			`CBR_B_SPC1: r = `CBR_L_SPC1;
			`CBR_B_SPC2: r = `CBR_L_SPC2;
			`CBR_B_SPC3: r = `CBR_L_SPC3;
			`CBR_B_SPC4: r = `CBR_L_SPC4;
			`CBR_B_RNGL: r = `CBR_L_RNGL;
			`CBR_B_RNGH: r = `CBR_L_RNGH;
			`CBR_B_RXM2: r = `CBR_L_RXM2;
			`CBR_B_RXM3: r = `CBR_L_RXM3;
			`CBR_B_LNX: r = `CBR_L_LNX;
			`CBR_B_CRC: r = `CBR_L_CRC;
			`CBR_B_RBP: r = `CBR_L_RBP;
			`CBR_B_RCO: r = `CBR_L_RCO;
			`CBR_B_TBP: r = `CBR_L_TBP;
			`CBR_B_TCO: r = `CBR_L_TCO;
			`CBR_B_CMD: r = `CBR_L_CMD;
			`CBR_B_STC: r = `CBR_L_STC;
			`CBR_B_STAT: r = `CBR_L_STAT;
			`CBR_B_MRTS: r = `CBR_L_MRTS;
			`CBR_B_MDTR: r = `CBR_L_MDTR;
			default: r = 8'hFF;
		endcase
		return r;
	endfunction : to_little

	// Channel source and map choice feed the decode below.
	always_comb begin
		eff_chan = ctx_active ? ctx_channel : s_q.channel_select[`CBR_SEL_CHAN_MSB:0];
		eff_proto = s_q.proto[{eff_chan, 1'b0} +: 2];
		norm_ofs = s_q.little ? paddr[9:2] : to_little(paddr[9:2]);
	end

	// Offset decode: class of register, protocol variant and whether the image carries it.
	always_comb begin
		dec_kind = K_CHAN;
		dec_var = 2'h0;
		dec_ok = 1'b1;
		unique case (norm_ofs)
			`CBR_L_REV: dec_kind = K_REV;
			`CBR_L_SEL: dec_kind = K_SEL;
			`CBR_L_STAT: dec_kind = K_STAT;
			`CBR_L_OPT7, `CBR_L_OPT6: begin
				// Option register normally, special mapped character in PPP.
				if (eff_proto == PR_PPP) begin
					dec_var = PR_PPP;
					dec_ok = image_caps[`CBR_CAP_PPP];
				end
			end
			`CBR_L_SPC1, `CBR_L_SPC2, `CBR_L_SPC3, `CBR_L_SPC4: begin
				// Special character, frame address or transmit map depending on protocol.
				dec_var = eff_proto;
				dec_ok = (eff_proto != PR_NONE) && image_caps[eff_proto];
			end
			`CBR_L_RNGL, `CBR_L_RNGH, `CBR_L_LNX: begin
				// Async and PPP only; sync has nothing here.
				dec_var = eff_proto;
				dec_ok = (eff_proto == PR_ASYNC || eff_proto == PR_PPP) && image_caps[eff_proto];
			end
			`CBR_L_RXM2, `CBR_L_RXM3: begin
				dec_var = PR_PPP;
				dec_ok = (eff_proto == PR_PPP) && image_caps[`CBR_CAP_PPP];
			end
			`CBR_L_CRC: begin
				dec_ok = (eff_proto == PR_SYNC) && image_caps[`CBR_CAP_SYNC];
			end
			`CBR_L_RBP, `CBR_L_RCO, `CBR_L_TBP, `CBR_L_TCO: dec_kind = K_CHAN;
			`CBR_L_MRTS, `CBR_L_MDTR: dec_kind = K_CHAN;
			`CBR_L_CMR, `CBR_L_OPT1, `CBR_L_OPT2, `CBR_L_OPT3: dec_kind = K_CHAN;
			`CBR_L_OPT4, `CBR_L_OPT5, `CBR_L_CMD, `CBR_L_STC: dec_kind = K_CHAN;
			default: dec_kind = K_NONE;
		endcase
	end

	// A per-channel write lands only in the copy of the latched channel.
	assign mem_we = (s_q.st == ST_RESP) && s_q.wr && !s_q.err && (s_q.kind == K_CHAN);

	// Sequencer: latch the request, read the memory, present data, then commit a write.
	always_comb begin
		s_d = s_q;
		s_d.little = pin_sync;
		s_d.act_chan = eff_chan;
		s_d.act_proto = eff_proto;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		unique case (s_q.st)
			ST_IDLE: begin
				if (psel && penable) begin
					s_d.chan = eff_chan;
					s_d.kind = dec_kind;
					s_d.slot = {dec_var, norm_ofs[7], norm_ofs[5:0]};
					s_d.wr = pwrite;
					s_d.wdata = pwdata[7:0];
					s_d.err = (dec_kind == K_NONE) || !dec_ok || (paddr[1:0] != 2'h0)
						|| (pwrite && dec_kind == K_STAT);
					s_d.st = ST_READ;
				end
			end
			ST_READ: begin
				// Memory read data become valid at the end of this cycle.
				s_d.st = ST_CAP;
			end
			ST_CAP: begin
				s_d.prdata = 32'h0000_0000;
				if (!s_q.err && !s_q.wr) begin
					unique case (s_q.kind)
						K_REV: s_d.prdata[7:0] = s_q.rev;
						K_SEL: s_d.prdata[7:0] = s_q.channel_select;
						K_STAT: s_d.prdata[7:0] = {5'h00, image_caps[s_q.proto[{s_q.chan, 1'b0} +: 2]],
							s_q.proto[{s_q.chan, 1'b0} +: 2]};
						K_CHAN: s_d.prdata[7:0] = mem_rdata;
						default: s_d.prdata = 32'h0000_0000;
					endcase
				end
				s_d.pready = 1'b1;
				s_d.pslverr = s_q.err;
				s_d.st = ST_RESP;
			end
			ST_RESP: begin
				// The write takes effect at the edge that completes the transfer.
				if (s_q.wr && !s_q.err) begin
					unique case (s_q.kind)
						K_REV: s_d.rev = s_q.wdata;
						K_SEL: s_d.channel_select = s_q.wdata;
						K_CHAN: begin
							// Mode writes also refresh the protocol copy that steers decode.
							if (s_q.slot == {2'h0, 1'b0, 6'(`CBR_L_CMR)}) begin
								s_d.proto[{s_q.chan, 1'b0} +: 2] = s_q.wdata[1:0];
							end
						end
						default: s_d.rev = s_q.rev;
					endcase
				end
				s_d.st = ST_IDLE;
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	// Single register stage for all of the bank's state outside the memory and the synchroniser.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.channel_select <= `CBR_RST_SEL;
			s_q.rev <= REV_INIT;
			s_q.little <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign active_chan = s_q.act_chan;
	assign active_proto = cbr_proto_t'(s_q.act_proto);
	assign sel_channel = s_q.channel_select[`CBR_SEL_CHAN_MSB:0];
	assign map_little = s_q.little;
endmodule : cbr_bank

// ===== tb/cbr_bank_assertions.sv
// Concurrent checks on the ports of the channel register bank.
`timescale 1ns/1ps
module cbr_bank_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic byte_order_pin,
	input wire logic ctx_active,
	input wire logic [1:0] ctx_channel,
	input wire logic [2:0] image_caps,
	input wire logic [1:0] active_chan,
	input wire cbr_pkg::cbr_proto_t active_proto,
	input wire logic [1:0] sel_channel,
	input wire logic map_little
);
	import cbr_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// A fresh access cycle opens a transfer; the answer is fixed at three edges later.
	sequence opened_s;
		psel && $rose(penable);
	endsequence
	sequence answered_s;
		##3 pready;
	endsequence
	answer_three_a: assert property (opened_s |-> answered_s) else $error("answer not three edges after request");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	ready_request_a: assert property (pready |-> psel && penable) else $error("ready without a request");
	error_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	upper_zero_a: assert property (prdata[31:8] == 24'h0) else $error("read data upper bits set");
	misalign_refused_a: assert property (psel && $rose(penable) && paddr[1:0] != 2'h0 |-> ##3 pslverr)
		else $error("misaligned access not refused");
	select_holds_a: assert property (!(psel && pwrite && pready) |=> $stable(sel_channel))
		else $error("channel select moved without a write");
	ctx_channel_a: assert property (ctx_active |=> active_chan == $past(ctx_channel))
		else $error("context channel not used");
	select_channel_a: assert property (!ctx_active |=> active_chan == $past(sel_channel))
		else $error("selected channel not used");
	map_follow_a: assert property ($stable(byte_order_pin)[*4] |=> map_little == $past(byte_order_pin))
		else $error("map does not follow byte order pin");
endmodule : cbr_bank_checker

bind cbr_bank cbr_bank_checker chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.byte_order_pin(byte_order_pin), .ctx_active(ctx_active), .ctx_channel(ctx_channel),
	.image_caps(image_caps), .active_chan(active_chan), .active_proto(active_proto),
	.sel_channel(sel_channel), .map_little(map_little));

// ===== tb/cbr_host.sv
// Bus master model of the host processor that reaches the register bank.
`timescale 1ns/1ps
module cbr_host (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [9:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// The bus is idle at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h0;
		pwdata = 32'h0;
	end

	// One transfer; address and data are inverted on release so stale values never look valid.
	task automatic xfer(input logic wr, input logic [9:0] addr, input logic [7:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~addr;
		pwdata <= ~{24'h0, wd};
	endtask : xfer
endmodule : cbr_host

// ===== tb/tb_top.sv
// Self-checking bench for the channel register bank.
`timescale 1ns/1ps
`include "cbr_consts.svh"
module tb_top;
	import cbr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic byte_order_pin = 1'b1;
	logic ctx_active = 1'b0;
	logic [1:0] ctx_channel = 2'h0;
	logic [2:0] image_caps = 3'h7;
	logic psel, penable, pwrite, pready, pslverr, map_little, err_v;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [1:0] active_chan, sel_channel;
	cbr_proto_t active_proto;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Plain per-channel registers, little map.
	logic [7:0] prw [9] = '{`CBR_L_TBP, `CBR_L_RBP, `CBR_L_RCO, `CBR_L_TCO, `CBR_L_MRTS, `CBR_L_MDTR,
		`CBR_L_CMD, `CBR_L_STC, `CBR_L_OPT1};

	always #50 clk = ~clk;

	cbr_bank dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .byte_order_pin(byte_order_pin),
		.ctx_active(ctx_active), .ctx_channel(ctx_channel), .image_caps(image_caps), .active_chan(active_chan),
		.active_proto(active_proto), .sel_channel(sel_channel), .map_little(map_little));
	cbr_host host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic end_of_test;
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// A hang counts as a mismatch.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
		cmp_count++;
		if (got !== want) begin
			err_total++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask : chk

	// Refused reads must return zero, so the data check covers both outcomes.
	task automatic acc(input logic wr, input logic [7:0] off, input logic [7:0] wd, input logic [7:0] want,
		input logic fail);
		host_u.xfer(wr, {off, 2'b00}, wd, rd_v, err_v);
		chk(32'(err_v), 32'(fail), "refusal");
		if (!wr)
			chk(rd_v, fail ? 32'h0 : {24'h0, want}, "read data");
	endtask : acc

	task automatic t_reset;
		acc(0, `CBR_L_REV, 8'h0, 8'h00, 0);
		acc(0, 8'h00, 8'h0, 8'h00, 1);
		host_u.xfer(0, {`CBR_L_REV, 2'b01}, 8'h0, rd_v, err_v);
		chk(32'(err_v), 32'h1, "misaligned");
		acc(1, `CBR_L_REV, 8'h5A, 8'h00, 0);
	endtask : t_reset

	task automatic t_banks;
		for (int c = 0; c < 4; c++) begin
			acc(1, `CBR_L_SEL, {6'h3F, c[1:0]}, 8'h0, 0);
			for (int r = 0; r < 9; r++)
				acc(1, prw[r], 8'(c * 16 + r + 1), 8'h0, 0);
		end
		for (int c = 0; c < 4; c++) begin
			acc(1, `CBR_L_SEL, {6'h00, c[1:0]}, 8'h0, 0);
			// The select register moves at the completing edge, so it is judged one edge later.
			@(posedge clk);
			chk(32'(sel_channel), 32'(c), "select");
			acc(0, `CBR_L_REV, 8'h0, 8'h5A, 0);
			for (int r = 0; r < 9; r++)
				acc(0, prw[r], 8'h0, 8'(c * 16 + r + 1), 0);
		end
	endtask : t_banks

	task automatic t_ctx;
		@(posedge clk);
		ctx_active <= 1'b1;
		ctx_channel <= 2'h1;
		acc(0, `CBR_L_TBP, 8'h0, 8'h11, 0);
		@(posedge clk);
		ctx_active <= 1'b0;
		acc(0, `CBR_L_TBP, 8'h0, 8'h31, 0);
	endtask : t_ctx

	// Channel 3 walks through the three protocols.
	task automatic t_proto;
		acc(1, `CBR_L_CMR, 8'h01, 8'h0, 0);
		// The protocol output trails the mode write by one registered stage.
		repeat (2) @(posedge clk);
		chk(32'(active_proto), 32'(PR_SYNC), "active protocol");
		acc(1, `CBR_L_SPC1, 8'h5C, 8'h0, 0);
		acc(1, `CBR_L_CRC, 8'h3C, 8'h0, 0);
		acc(0, `CBR_L_SPC1, 8'h0, 8'h5C, 0);
		acc(1, `CBR_L_CMR, 8'h00, 8'h0, 0);
		acc(0, `CBR_L_SPC1, 8'h0, 8'h00, 0);
		acc(0, `CBR_L_CRC, 8'h0, 8'h00, 1);
		acc(0, `CBR_L_RXM2, 8'h0, 8'h00, 1);
		acc(0, `CBR_L_STAT, 8'h0, 8'h04, 0);
		acc(1, `CBR_L_STAT, 8'h99, 8'h0, 1);
		acc(1, `CBR_L_CMR, 8'h02, 8'h0, 0);
		acc(0, `CBR_L_SPC1, 8'h0, 8'h00, 0);
		acc(1, `CBR_L_RXM2, 8'h77, 8'h0, 0);
		acc(0, `CBR_L_RXM2, 8'h0, 8'h77, 0);
		@(posedge clk);
		image_caps <= 3'h3;
		acc(0, `CBR_L_RXM2, 8'h0, 8'h00, 1);
		@(posedge clk);
		image_caps <= 3'h7;
		acc(1, `CBR_L_OPT6, 8'h66, 8'h0, 0);
		acc(0, `CBR_L_OPT6, 8'h0, 8'h66, 0);
		acc(1, `CBR_L_CMR, 8'h03, 8'h0, 0);
		acc(0, `CBR_L_SPC1, 8'h0, 8'h00, 1);
		acc(1, `CBR_L_CMR, 8'h00, 8'h0, 0);
		acc(0, `CBR_L_OPT6, 8'h0, 8'h00, 0);
	endtask : t_proto

	// The synchroniser needs a few edges, so the map is judged only after it settles.
	task automatic t_maps;
		@(posedge clk);
		byte_order_pin <= 1'b0;
		repeat (5) @(posedge clk);
		chk(32'(map_little), 32'h0, "map");
		acc(0, `CBR_B_REV, 8'h0, 8'h5A, 0);
		acc(0, `CBR_B_TBP, 8'h0, 8'h31, 0);
		acc(0, `CBR_L_SEL, 8'h0, 8'h00, 1);
		acc(1, `CBR_B_SEL, 8'h01, 8'h0, 0);
		@(posedge clk);
		chk(32'(sel_channel), 32'h1, "big map select");
		@(posedge clk);
		byte_order_pin <= 1'b1;
		repeat (5) @(posedge clk);
		acc(0, `CBR_L_TBP, 8'h0, 8'h11, 0);
	endtask : t_maps

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_banks();
		t_ctx();
		t_proto();
		t_maps();
		end_of_test();
	end
endmodule : tb_top
